/* src/etd_pkg.sv */
package etd_pkg;

  // Clock and time base.
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned BASE_TICK_MS   = 10;
  localparam int unsigned NS_PER_MS      = 1000000;
  localparam int unsigned BASE_TICK_CYC  = (BASE_TICK_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int unsigned UNIT_STEP      = 10;

  // Widths.
  localparam int unsigned ADDR_W   = 5;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned PRESET_W = 15;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] CTRL_ADDR        = 5'h00;
  localparam logic [ADDR_W-1:0] ON_PRESET_ADDR   = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_PRESET_ADDR  = 5'h08;
  localparam logic [ADDR_W-1:0] ON_ELAPSED_ADDR  = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_ELAPSED_ADDR = 5'h10;
  localparam logic [ADDR_W-1:0] STATUS_ADDR      = 5'h14;

  // Control register fields.
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_ON_EN    = 2;
  localparam int unsigned CTRL_OFF_EN   = 3;
  localparam int unsigned CTRL_UNIT_LSB = 4;
  localparam int unsigned CTRL_W        = 6;

  // Status register fields.
  localparam int unsigned STAT_PULSE  = 0;
  localparam int unsigned STAT_TOGGLE = 1;
  localparam int unsigned STAT_DELAY  = 2;

  // Pulse trigger modes.
  typedef enum logic [1:0] {
    rising_transition_mode  = 2'b00,
    falling_transition_mode = 2'b01,
    dual_transition_mode    = 2'b10
  } etd_mode_t;

  // Time units of the delay timer.
  typedef enum logic [1:0] {
    UNIT_10MS  = 2'b00,
    UNIT_100MS = 2'b01,
    UNIT_1S    = 2'b10
  } etd_unit_t;

  // Reset values.
  localparam logic [CTRL_W-1:0]   CTRL_RST   = 6'h00;
  localparam logic [PRESET_W-1:0] PRESET_RST = 15'h0000;

endpackage

/* src/etd_prescaler.sv */
`timescale 1ns/1ns
// Derives the 10 ms, 100 ms and 1 s ticks from the system clock and
// passes the selected one on as a single-cycle enable.
module etd_prescaler #(
  parameter int unsigned BASE_CYCLES = etd_pkg::BASE_TICK_CYC
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] unit_i,
  output logic            tick_o
);

  logic [31:0] base_cnt_reg;
  logic [3:0]  dec1_reg;
  logic [3:0]  dec2_reg;
  wire         base_wrap;
  wire         d1_wrap;
  wire         d2_wrap;
  wire         sel_tick;

  ////////////////////////////////////////////////////////////////////////
  // Wrap strobes of the three stages.
  assign base_wrap = (base_cnt_reg == BASE_CYCLES - 1);
  assign d1_wrap   = base_wrap && (dec1_reg == 4'(etd_pkg::UNIT_STEP - 1));
  assign d2_wrap   = d1_wrap && (dec2_reg == 4'(etd_pkg::UNIT_STEP - 1));
  assign sel_tick  = (unit_i == etd_pkg::UNIT_10MS)  ? base_wrap :
                     (unit_i == etd_pkg::UNIT_100MS) ? d1_wrap   :
                     (unit_i == etd_pkg::UNIT_1S)    ? d2_wrap   : 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // The chain runs free, so a unit change takes effect at the next wrap.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      base_cnt_reg <= 32'h0000_0000;
      dec1_reg     <= 4'h0;
      dec2_reg     <= 4'h0;
      tick_o       <= 1'b0;
    end
    else
    begin
      base_cnt_reg <= base_wrap ? 32'h0000_0000 : base_cnt_reg + 32'h0000_0001;
      if (base_wrap)
        dec1_reg <= d1_wrap ? 4'h0 : dec1_reg + 4'h1;
      if (d1_wrap)
        dec2_reg <= d2_wrap ? 4'h0 : dec2_reg + 4'h1;
      tick_o <= sel_tick;
    end
  end

endmodule

/* src/etd_top.sv */
// Operation
// - Pulser emits one pulse per configured trigger transition, else low.
// - Pulser modes: falling only, rising only, or either transition.
// - Toggle output inverts on each inactive-to-active trigger change.
// - Toggle clear forces output inactive regardless of trigger.
// - ON delay: output rises after input held active for ON preset.
// - OFF delay: output falls after input held inactive for OFF preset.
// - ON and OFF delays enable separately or together.
// - ON delay only: output follows input low immediately.
// - Clear zeroes both elapsed counts, cancels operation, output inactive.
// - Clear with input active keeps delay output inactive.
// - Time unit selectable: 10 ms, 100 ms or 1 s tick.
// - Presets range 0 to 32767 ticks.
// - Presets and elapsed counts readable by other blocks.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module etd_top #(
  parameter int unsigned TICK_BASE_CYCLES = etd_pkg::BASE_TICK_CYC,
  parameter int unsigned PRESET_W         = etd_pkg::PRESET_W
) (
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_i,
  // Avalon-MM slave.
  input  wire logic [etd_pkg::ADDR_W-1:0]  avs_address_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic [etd_pkg::DATA_W-1:0]  avs_writedata_i,
  input  wire logic [3:0]                  avs_byteenable_i,
  output logic      [etd_pkg::DATA_W-1:0]  avs_readdata_o,
  output logic                             avs_waitrequest_o,
  // Function block signals.
  input  wire logic                        pulse_trig_i,
  input  wire logic                        toggle_trig_i,
  input  wire logic                        toggle_clr_i,
  input  wire logic                        delay_in_i,
  input  wire logic                        delay_clr_i,
  output logic                             pulse_o,
  output logic                             toggle_o,
  output logic                             delay_o,
  output logic      [PRESET_W-1:0]         on_preset_o,
  output logic      [PRESET_W-1:0]         on_elapsed_o,
  output logic      [PRESET_W-1:0]         off_preset_o,
  output logic      [PRESET_W-1:0]         off_elapsed_o
);

  // Rising transition of a sampled level against its previous sample.
  function automatic logic rose(input logic cur, input logic prev);
    rose = cur & ~prev;
  endfunction

  // Writes a 32-bit word under byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        res[i*8 +: 8] = wd[i*8 +: 8];
    merge = res;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register bus.
  logic [etd_pkg::CTRL_W-1:0] ctrl_reg;
  logic                       pulse_prev_reg;
  logic                       toggle_prev_reg;
  wire                        bus_req;
  wire                        bus_do;
  wire                        wr_ctrl;
  wire                        wr_on;
  wire                        wr_off;
  wire  [31:0]                ctrl_word;
  wire  [31:0]                on_word;
  wire  [31:0]                off_word;
  wire  [31:0]                stat_word;
  wire  [31:0]                rd_mux;
  wire  [31:0]                ctrl_merged;
  wire  [31:0]                on_merged;
  wire  [31:0]                off_merged;
  wire  [1:0]                 mode_sel;
  wire                        on_en;
  wire                        off_en;
  wire  [1:0]                 unit_sel;
  wire                        tick;

  // A request is answered one cycle after it is seen; waitrequest drops
  // for exactly that cycle, and the access completes at its closing edge.
  assign bus_req = avs_read_i | avs_write_i;
  assign bus_do  = bus_req & ~avs_waitrequest_o;
  assign wr_ctrl = bus_do & avs_write_i & (avs_address_i == etd_pkg::CTRL_ADDR);
  assign wr_on   = bus_do & avs_write_i & (avs_address_i == etd_pkg::ON_PRESET_ADDR);
  assign wr_off  = bus_do & avs_write_i & (avs_address_i == etd_pkg::OFF_PRESET_ADDR);

  assign ctrl_word = {{(32-etd_pkg::CTRL_W){1'b0}}, ctrl_reg};
  assign on_word   = {{(32-PRESET_W){1'b0}}, on_preset_o};
  assign off_word  = {{(32-PRESET_W){1'b0}}, off_preset_o};
  assign stat_word = {29'h0000_0000, delay_o, toggle_o, pulse_o};

  assign ctrl_merged = merge(ctrl_word, avs_writedata_i, avs_byteenable_i);
  assign on_merged   = merge(on_word, avs_writedata_i, avs_byteenable_i);
  assign off_merged  = merge(off_word, avs_writedata_i, avs_byteenable_i);

  // Read decode; unmapped addresses read as zero and ignore writes.
  assign rd_mux = (avs_address_i == etd_pkg::CTRL_ADDR)        ? ctrl_word :
                  (avs_address_i == etd_pkg::ON_PRESET_ADDR)   ? on_word   :
                  (avs_address_i == etd_pkg::OFF_PRESET_ADDR)  ? off_word  :
                  (avs_address_i == etd_pkg::ON_ELAPSED_ADDR)  ?
                    {{(32-PRESET_W){1'b0}}, on_elapsed_o} :
                  (avs_address_i == etd_pkg::OFF_ELAPSED_ADDR) ?
                    {{(32-PRESET_W){1'b0}}, off_elapsed_o} :
                  (avs_address_i == etd_pkg::STATUS_ADDR)      ? stat_word : 32'h0000_0000;

  // Bus handshake and read data.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
      if (avs_read_i & avs_waitrequest_o)
        avs_readdata_o <= rd_mux;
    end
  end

  // Configuration registers. Presets are 15 bits wide, so 0 to 32767.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg     <= etd_pkg::CTRL_RST;
      on_preset_o  <= etd_pkg::PRESET_RST;
      off_preset_o <= etd_pkg::PRESET_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= ctrl_merged[etd_pkg::CTRL_W-1:0];
      if (wr_on)
        on_preset_o <= on_merged[PRESET_W-1:0];
      if (wr_off)
        off_preset_o <= off_merged[PRESET_W-1:0];
    end
  end

  assign mode_sel = ctrl_reg[etd_pkg::CTRL_MODE_LSB +: 2];
  assign on_en    = ctrl_reg[etd_pkg::CTRL_ON_EN];
  assign off_en   = ctrl_reg[etd_pkg::CTRL_OFF_EN];
  assign unit_sel = ctrl_reg[etd_pkg::CTRL_UNIT_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////
  // Edge pulser. Comparing with the previous sample means a pulse can
  // only last one cycle, and each transition is judged on its own.
  wire  p_rise;
  wire  p_fall;
  logic p_hit;

  assign p_rise = rose(pulse_trig_i, pulse_prev_reg);
  assign p_fall = rose(pulse_prev_reg, pulse_trig_i);

  always_comb
  begin
    unique case (mode_sel)
      etd_pkg::rising_transition_mode:  p_hit = p_rise;
      etd_pkg::falling_transition_mode: p_hit = p_fall;
      etd_pkg::dual_transition_mode:    p_hit = p_rise | p_fall;
      default:                          p_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pulse_prev_reg <= 1'b0;
      pulse_o        <= 1'b0;
    end
    else
    begin
      pulse_prev_reg <= pulse_trig_i;
      pulse_o        <= p_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Toggle block. Clear is tested first so it beats a coincident trigger.
  wire t_act;

  assign t_act = rose(toggle_trig_i, toggle_prev_reg);

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      toggle_prev_reg <= 1'b0;
      toggle_o        <= 1'b0;
    end
    else
    begin
      toggle_prev_reg <= toggle_trig_i;
      if (toggle_clr_i)
        toggle_o <= 1'b0;
      else if (t_act)
        toggle_o <= ~toggle_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Delay timer tick.
  etd_prescaler #(
    .BASE_CYCLES (TICK_BASE_CYCLES)
  ) u_prescaler (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .unit_i    (unit_sel),
    .tick_o    (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Delay timer. Each phase first checks whether its preset is reached and
  // only then counts, so a zero preset acts in the next cycle. A nonzero
  // preset ends on a tick, and as the tick runs free it may end under one tick early.
  wire on_phase;
  wire off_phase;
  wire on_done;
  wire off_done;
  wire max_on;
  wire max_off;

  assign on_phase  = delay_in_i & ~delay_o & on_en;
  assign off_phase = ~delay_in_i & delay_o & off_en;
  assign on_done   = (on_elapsed_o >= on_preset_o);
  assign off_done  = (off_elapsed_o >= off_preset_o);
  assign max_on    = &on_elapsed_o;
  assign max_off   = &off_elapsed_o;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      delay_o       <= 1'b0;
      on_elapsed_o  <= etd_pkg::PRESET_RST;
      off_elapsed_o <= etd_pkg::PRESET_RST;
    end
    else if (delay_clr_i)
    begin
      delay_o       <= 1'b0;
      on_elapsed_o  <= etd_pkg::PRESET_RST;
      off_elapsed_o <= etd_pkg::PRESET_RST;
    end
    else
    begin
      // ON side: count while waiting, restart whenever input falls.
      if (!delay_in_i)
        on_elapsed_o <= etd_pkg::PRESET_RST;
      else if (on_phase && !on_done && tick && !max_on)
        on_elapsed_o <= on_elapsed_o + 1'b1;
      // OFF side: count while waiting, restart whenever input rises.
      if (delay_in_i)
        off_elapsed_o <= etd_pkg::PRESET_RST;
      else if (off_phase && !off_done && tick && !max_off)
        off_elapsed_o <= off_elapsed_o + 1'b1;
      // Output decision.
      if (delay_in_i && !delay_o)
        delay_o <= on_en ? on_done : 1'b1;
      else if (!delay_in_i && delay_o)
        delay_o <= off_en ? ~off_done : 1'b0;
    end
  end

endmodule

/* tb/etd_top_sva.sv */
`timescale 1ns/1ns
// Port-level checker for the pulse, toggle and delay blocks.
module etd_top_sva #(
  parameter int unsigned PRESET_W = 15
) (
  input wire logic                sys_clk_i,
  input wire logic                rst_i,
  input wire logic                avs_read_i,
  input wire logic                avs_write_i,
  input wire logic                avs_waitrequest_o,
  input wire logic                pulse_trig_i,
  input wire logic                toggle_trig_i,
  input wire logic                toggle_clr_i,
  input wire logic                delay_in_i,
  input wire logic                delay_clr_i,
  input wire logic                pulse_o,
  input wire logic                toggle_o,
  input wire logic                delay_o,
  input wire logic [PRESET_W-1:0] on_preset_o,
  input wire logic [PRESET_W-1:0] on_elapsed_o,
  input wire logic [PRESET_W-1:0] off_elapsed_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Edge history taken across reset is stale, so the pulse check waits two clean cycles and the toggle check one.
  logic [1:0] rst_hist;
  always_ff @(posedge sys_clk_i)
  begin
    rst_hist <= {rst_hist[0], rst_i};
  end
  // A bus access is one wait cycle, then a one-cycle answer.
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_ans;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  a_bus_answer: assert property (s_req |=> s_ans)
    else $error("bus answer timing wrong");
  a_pulse_cause: assert property (pulse_o && rst_hist == 2'b00 |->
    $past(pulse_trig_i) != $past(pulse_trig_i, 2)) else $error("pulse without transition");
  a_toggle_clear: assert property (toggle_clr_i |=> !toggle_o)
    else $error("toggle not cleared");
  a_toggle_flip: assert property (!toggle_clr_i && toggle_trig_i && !$past(toggle_trig_i) &&
    !rst_hist[0] |=> toggle_o != $past(toggle_o)) else $error("toggle did not invert");
  a_delay_clear: assert property (delay_clr_i |=> !delay_o &&
    on_elapsed_o == '0 && off_elapsed_o == '0) else $error("delay clear ignored");
  a_delay_rise: assert property ($rose(delay_o) |-> $past(delay_in_i) && !$past(delay_clr_i))
    else $error("delay rose without input");
  a_elapsed_step: assert property (!delay_clr_i |=> on_elapsed_o == '0 ||
    on_elapsed_o == $past(on_elapsed_o) || on_elapsed_o == $past(on_elapsed_o) + 1'b1)
    else $error("elapsed jumped");
  a_preset_hold: assert property (!(avs_write_i && !avs_waitrequest_o) |=> $stable(on_preset_o))
    else $error("preset changed without write");
endmodule

bind etd_top etd_top_sva #(.PRESET_W(PRESET_W)) u_etd_top_sva (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .pulse_trig_i(pulse_trig_i), .toggle_trig_i(toggle_trig_i),
  .toggle_clr_i(toggle_clr_i), .delay_in_i(delay_in_i), .delay_clr_i(delay_clr_i),
  .pulse_o(pulse_o), .toggle_o(toggle_o), .delay_o(delay_o), .on_preset_o(on_preset_o),
  .on_elapsed_o(on_elapsed_o), .off_elapsed_o(off_elapsed_o));

/* tb/etd_bus_model.sv */
`timescale 1ns/1ns
// Avalon-MM master standing in for the configuring program.
module etd_bus_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        go_i,
  input  wire logic        wr_i,
  input  wire logic [4:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        waitreq_i,
  input  wire logic [31:0] rdata_i,
  output logic             read_o,
  output logic             write_o,
  output logic [4:0]       addr_o,
  output logic [31:0]      wdata_o,
  output logic             done_o,
  output logic [31:0]      data_o
);
  // The request stands until waitrequest is seen low; released data is inverted so no stale value passes.
  always_ff @(posedge clk_i)
  begin
    done_o <= 1'b0;
    if (rst_i)
    begin
      read_o  <= 1'b0;
      write_o <= 1'b0;
    end
    else if ((read_o || write_o) && !waitreq_i)
    begin
      data_o  <= rdata_i;
      read_o  <= 1'b0;
      write_o <= 1'b0;
      wdata_o <= ~wdata_o;
      done_o  <= 1'b1;
    end
    else if (go_i && !read_o && !write_o)
    begin
      read_o  <= !wr_i;
      write_o <= wr_i;
      addr_o  <= addr_i;
      wdata_o <= wdata_i;
    end
  end
endmodule

/* tb/etd_top_tb.sv */
`timescale 1ns/1ns
module etd_top_tb;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        go = 1'b0, wr = 1'b0, rd_o, wr_o, done, wreq;
  logic [4:0]  ad = 5'h00, ad_o;
  logic [31:0] wd = 32'h0, wd_o, rdata, bus_q;
  logic        ptrig = 1'b0, ttrig = 1'b0, tclr = 1'b0, din = 1'b0, dclr = 1'b0;
  logic        pls, tgl, dly;
  logic [14:0] onp, one, offp, offe;
  int          n_errors = 0, num_checks = 0, cyc = 0, pcnt = 0;
  ////////////////////////////////////////
  etd_top #(.TICK_BASE_CYCLES(10)) u_etd_top (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(ad_o), .avs_read_i(rd_o), .avs_write_i(wr_o),
    .avs_writedata_i(wd_o), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .pulse_trig_i(ptrig), .toggle_trig_i(ttrig), .toggle_clr_i(tclr), .delay_in_i(din),
    .delay_clr_i(dclr), .pulse_o(pls), .toggle_o(tgl), .delay_o(dly), .on_preset_o(onp),
    .on_elapsed_o(one), .off_preset_o(offp), .off_elapsed_o(offe));
  etd_bus_model u_etd_bus_model (
    .clk_i(sys_clk_i), .rst_i(rst_i), .go_i(go), .wr_i(wr), .addr_i(ad), .wdata_i(wd), .waitreq_i(wreq),
    .rdata_i(rdata), .read_o(rd_o), .write_o(wr_o), .addr_o(ad_o), .wdata_o(wd_o), .done_o(done),
    .data_o(bus_q));
  // Free-running 50 MHz clock.
  always #10 sys_clk_i = ~sys_clk_i;
  // Cycle ceiling cuts a hung handshake short; pulses are tallied here too.
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (pls === 1'b1)
      pcnt <= pcnt + 1;
    if (cyc == 20000)
    begin
      n_errors = n_errors + 1;
      stop_test();
    end
  end
  ////////////////////////////////////////
  task automatic stop_test();
    begin
      $display("errors %0d checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic ck(input string s, input logic [31:0] e, input logic [31:0] g);
    begin
      num_checks++;
      if (g !== e)
      begin
        n_errors++;
        $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
    end
  endtask
  // One bus access; the model's done pulse ends it, the global ceiling bounds it.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    begin
      @(posedge sys_clk_i);
      go <= 1'b1;
      wr <= w;
      ad <= a;
      wd <= d;
      @(posedge sys_clk_i);
      go <= 1'b0;
      while (done !== 1'b1)
        @(posedge sys_clk_i);
    end
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    begin
      bus(1'b0, etd_pkg::CTRL_ADDR, 32'h0);
      ck("ctrl reset", 32'h0, bus_q);
      bus(1'b1, etd_pkg::ON_PRESET_ADDR, 32'h7fff);
      bus(1'b0, etd_pkg::ON_PRESET_ADDR, 32'h0);
      ck("on preset", 32'h7fff, bus_q);
      ck("on preset port", 32'h7fff, {17'h0, onp});
      bus(1'b1, etd_pkg::ON_ELAPSED_ADDR, 32'h1234);
      bus(1'b0, etd_pkg::ON_ELAPSED_ADDR, 32'h0);
      ck("elapsed read only", 32'h0, bus_q);
      bus(1'b0, 5'h18, 32'h0);
      ck("unmapped", 32'h0, bus_q);
    end
  endtask
  // Slow rise, slow fall, then a back-to-back pair in every mode.
  task automatic t_pulse();
    int exp;
    begin
      for (int m = 0; m < 3; m++)
      begin
        bus(1'b1, etd_pkg::CTRL_ADDR, 32'(m));
        pcnt = 0;
        exp = ((m != 1) + (m != 0)) * 2;
        ptrig <= 1'b1;
        cy(3);
        ptrig <= 1'b0;
        cy(3);
        ptrig <= 1'b1;
        cy(1);
        ptrig <= 1'b0;
        cy(3);
        ck("pulse count", 32'(exp), 32'(pcnt));
      end
    end
  endtask
  task automatic t_toggle();
    begin
      ttrig <= 1'b1;
      cy(2);
      ck("toggle on", 32'h1, {31'h0, tgl});
      ttrig <= 1'b0;
      cy(1);
      ttrig <= 1'b1;
      tclr <= 1'b1;
      cy(2);
      ck("clear wins", 32'h0, {31'h0, tgl});
      ttrig <= 1'b0;
      tclr <= 1'b0;
      cy(1);
      ttrig <= 1'b1;
      cy(2);
      ck("toggle again", 32'h1, {31'h0, tgl});
      ttrig <= 1'b0;
      cy(1);
      ttrig <= 1'b1;
      cy(2);
      ck("toggle off", 32'h0, {31'h0, tgl});
    end
  endtask
  // ON delay of two ticks in each unit; the tick phase is free, so one tick of slack is allowed.
  task automatic t_units();
    int p;
    begin
      for (int u = 0; u < 3; u++)
      begin
        p = 10 * (10 ** u);
        bus(1'b1, etd_pkg::CTRL_ADDR, 32'(u * 16 + 4));
        bus(1'b1, etd_pkg::ON_PRESET_ADDR, 32'h2);
        din <= 1'b1;
        cy(p * 9 / 10);
        ck("on early", 32'h0, {31'h0, dly});
        cy(2 * p + 20);
        ck("on late", 32'h1, {31'h0, dly});
        ck("on elapsed", 32'h2, {17'h0, one});
        din <= 1'b0;
        cy(2);
        ck("on drop", 32'h0, {31'h0, dly});
      end
    end
  endtask
  task automatic t_off();
    begin
      bus(1'b1, etd_pkg::CTRL_ADDR, 32'h8);
      bus(1'b1, etd_pkg::OFF_PRESET_ADDR, 32'h3);
      ck("off preset port", 32'h3, {17'h0, offp});
      din <= 1'b1;
      cy(3);
      ck("off follows", 32'h1, {31'h0, dly});
      din <= 1'b0;
      cy(5);
      ck("off hold", 32'h1, {31'h0, dly});
      cy(40);
      ck("off release", 32'h0, {31'h0, dly});
      bus(1'b1, etd_pkg::CTRL_ADDR, 32'hc);
      din <= 1'b1;
      cy(20);
      dclr <= 1'b1;
      cy(3);
      ck("clear out", 32'h0, {31'h0, dly});
      ck("clear counts", 32'h0, {2'h0, one, offe});
      dclr <= 1'b0;
      cy(50);
      ck("both on", 32'h1, {31'h0, dly});
      bus(1'b0, etd_pkg::STATUS_ADDR, 32'h0);
      ck("status word", 32'h4, bus_q);
      bus(1'b0, etd_pkg::OFF_PRESET_ADDR, 32'h0);
      ck("off preset read", 32'h3, bus_q);
    end
  endtask
  ////////////////////////////////////////
  // Reset for three cycles, then every scenario in turn.
  initial
  begin
    cy(3);
    rst_i <= 1'b0;
    cy(1);
    t_regs();
    t_pulse();
    t_toggle();
    t_units();
    t_off();
    stop_test();
  end
endmodule
